// file: src/sis_pkg.sv
// shared constants for the sdram init / self-refresh sequencer pair
// assumes a single 50 MHz clock shared by controller and device model
package sis_pkg;
  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS    = 20;       // clk period
  localparam int STABLE_TIME_US   = 200;      // power-up clock stable time
  localparam int ROW_ACTIVE_NS    = 42;       // row-active minimum, fast grade
  localparam int ROW_CYCLE_NS     = 60;       // row-cycle minimum, fast grade
  localparam int SRX_TIME_NS      = 20;       // self-refresh exit hold, plain default
  localparam int PRECHARGE_NS     = 18;       // precharge to refresh
  // least times round up to whole cycles
  localparam int STABLE_CYC = (STABLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAS_CYC    = (ROW_ACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RC_CYC     = (ROW_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SRX_CYC    = (SRX_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RP_CYC     = (PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_REFRESH_CNT  = 2;       // refreshes in initialisation
  localparam int BURST_REFRESH_CNT = 2048;    // burst refresh around self-refresh
  localparam int CNT_W             = 16;      // width of delay counters
  // ****************************************************************
  // command encoding {cs_n, ras_n, cas_n, we_n}
  // ****************************************************************
  localparam logic [3:0] CMD_NOP   = 4'h7;    // no_operation_cmd
  localparam logic [3:0] CMD_DESEL = 4'h8;    // chip deselected
  localparam logic [3:0] CMD_PRE   = 4'h2;    // precharge
  localparam logic [3:0] CMD_MRS   = 4'h0;    // mode register set
  localparam logic [3:0] CMD_REF   = 4'h1;    // auto_refresh_cmd / self entry
  localparam logic [10:0] ADDR_ALL_BANKS = 11'h400; // a10 high selects all banks
  localparam logic [10:0] MODE_DEFAULT   = 11'h020; // cas latency 2, burst 1
  localparam logic [1:0]  DEV_INIT  = 2'h0;   // device status codes
  localparam logic [1:0]  DEV_READY = 2'h1;
  localparam logic [1:0]  DEV_SELF  = 2'h2;
  localparam logic [1:0]  DEV_ERROR = 2'h3;
endpackage : sis_pkg

// file: src/sis_link_if.sv
// control pins between controller and sdram device end
// assumes both ends run on the same clk
`timescale 1ns/10ps
interface sis_link_if;
  logic        cke;             // clock enable
  logic        cs_n;            // chip select, active low
  logic        ras_n;           // row strobe
  logic        cas_n;           // column strobe
  logic        we_n;            // write strobe
  logic [10:0] addr;            // address
  logic        ba;              // bank select
  logic        low_byte_mask;   // byte masks
  logic        high_byte_mask;
  logic        clk_run;         // controller lets the memory clock run
  modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, addr, ba, low_byte_mask, high_byte_mask, clk_run);
  modport dev  (input  cke, cs_n, ras_n, cas_n, we_n, addr, ba, low_byte_mask, high_byte_mask, clk_run);
endinterface : sis_link_if

// file: src/sis_dev.sv
// device end: watches init sequence and tracks self-refresh
// assumes controller end drives the link on the same clk
`timescale 1ns/10ps
module sis_dev
  import sis_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   reset,
  sis_link_if.dev     link,
  output logic [1:0]  dev_state,     // init / ready / self / error
  output logic        in_self,       // self-refresh active
  output logic [10:0] mode_value     // last mode register loaded
);
  typedef enum {S_WAIT_CKE, S_WAIT_PRE, S_CONFIG, S_READY, S_SELF, S_ERR} sis_dstate_e;
  sis_dstate_e  st, next_st;          // device state
  logic [1:0]   ref_cnt, next_ref_cnt;// init refreshes seen, saturates
  logic         mrs_done, next_mrs_done;
  logic [10:0]  next_mode_value;
  logic [1:0]   next_dev_state;
  logic [3:0]   cmd;                  // sampled command
  logic         sel;                  // chip selected with cke high

  assign cmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
  assign sel = link.cke && !link.cs_n;

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb
  begin
    next_st         = st;
    next_ref_cnt    = ref_cnt;
    next_mrs_done   = mrs_done;
    next_mode_value = mode_value;
    case (st)
      S_WAIT_CKE:
      begin
        if (link.cke)
          next_st = S_WAIT_PRE;
      end
      S_WAIT_PRE:
      begin
        // first command must be precharge of all banks; no-op and deselect skipped  R21
        if (sel && cmd != CMD_NOP)
        begin
          if (cmd == CMD_PRE && link.addr[10])
            next_st = S_CONFIG;
          else
            next_st = S_ERR;
        end
      end
      S_CONFIG:
      begin
        // refreshes may come before or after mode set  R7
        if (sel && cmd == CMD_REF)
        begin
          if (ref_cnt != 2'(INIT_REFRESH_CNT))
            next_ref_cnt = ref_cnt + 2'h1;
        end
        else if (sel && cmd == CMD_MRS)
        begin
          next_mrs_done   = 1'b1;
          next_mode_value = link.addr;
        end
        if (next_mrs_done && next_ref_cnt == 2'(INIT_REFRESH_CNT))
          next_st = S_READY;
      end
      S_READY:
      begin
        // cs, ras, cas low with cke low enters self-refresh  R8 R20
        if (!link.cke && cmd == CMD_REF)
          next_st = S_SELF;
        else if (sel && cmd == CMD_MRS)
          next_mode_value = link.addr;
      end
      S_SELF:
      begin
        // only cke is looked at; clock and strobes ignored  R9 R10
        if (link.cke)
          next_st = S_READY;
      end
      S_ERR:
        next_st = S_ERR;
      default:
        next_st = S_ERR;
    endcase
    case (next_st)
      S_READY: next_dev_state = DEV_READY;
      S_SELF:  next_dev_state = DEV_SELF;
      S_ERR:   next_dev_state = DEV_ERROR;
      default: next_dev_state = DEV_INIT;
    endcase
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st         <= S_WAIT_CKE;
      ref_cnt    <= 2'h0;
      mrs_done   <= 1'b0;
      mode_value <= 11'h000;
      dev_state  <= DEV_INIT;
      in_self    <= 1'b0;
    end
    else
    begin
      st         <= next_st;
      ref_cnt    <= next_ref_cnt;
      mrs_done   <= next_mrs_done;
      mode_value <= next_mode_value;
      dev_state  <= next_dev_state;
      in_self    <= (next_st == S_SELF);
    end
  end
endmodule : sis_dev

// file: src/sis_ctrl.sv
// controller end: power-up init and self-refresh entry/exit
// assumes a user that requests self-refresh by level
// How it works
// R1 - power-up: cke low, masks high, no-op
// R2 - clock stable 200 us before cke
// R3 - masks stay high while cke rises
// R4 - precharge all banks after cke
// R5 - mode register set during init
// R6 - at least two init auto-refreshes
// R7 - refreshes before or after mode set
// R8 - cs, ras, cas, cke low enters
// R9 - device ignores all but cke after
// R10 - stays in self-refresh while cke low
// R11 - wait row-active time before exit
// R12 - restart clock, stable, then cke high
// R13 - hold cke high for exit time
// R14 - exit starts deselected, no command
// R15 - row-cycle time before next command
// R16 - burst refresh 2048 before and after
// R17 - ns minimums rounded up to cycles
// R18 - row-active time 42 ns fast grade
// R19 - row-cycle time 60 ns fast grade
// R20 - entry has write strobe high
// R21 - no-op is deselect or high strobes
`timescale 1ns/10ps
module sis_ctrl
  import sis_pkg::*;
#(
  parameter int STABLE_CYCLES = STABLE_CYC,        // shortenable power-up wait
  parameter int BURST_REFRESH = BURST_REFRESH_CNT, // refreshes around self-refresh
  parameter bit USE_BURST     = 1'b1               // burst refresh mode
)
(
  input  wire logic clk,
  input  wire logic reset,
  sis_link_if.ctrl  link,
  input  wire logic self_req,        // level: stay in self-refresh
  output logic      init_done,       // device ready for accesses
  output logic      self_active      // device in self-refresh
);
  typedef enum {C_STABLE, C_PRE, C_TRP, C_REF, C_MRS, C_IDLE, C_BREF_IN, C_ENTER,
                C_DWELL, C_SELF, C_CLKUP, C_EXIT, C_BREF_OUT} sis_cstate_e;
  sis_cstate_e       st, next_st;
  logic [CNT_W-1:0]  wait_cnt, next_wait_cnt;   // delay counter
  logic [CNT_W-1:0]  ref_cnt, next_ref_cnt;     // refreshes issued
  logic [3:0]        next_cmd;
  logic              next_cke, next_clk_run, next_mask;
  logic [10:0]       next_addr;
  logic              next_init_done, next_self_active;

  // cycles to count, minus one for the issuing cycle
  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = (n > 1) ? CNT_W'(n - 1) : '0;
  endfunction : cyc

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb
  begin
    next_st          = st;
    next_wait_cnt    = (wait_cnt != '0) ? wait_cnt - 1'b1 : wait_cnt;
    next_ref_cnt     = ref_cnt;
    next_cmd         = CMD_NOP;              // R21
    next_cke         = link.cke;
    next_clk_run     = 1'b1;
    next_mask        = 1'b0;
    next_addr        = 11'h000;
    next_init_done   = init_done;
    next_self_active = self_active;
    case (st)
      C_STABLE:
      begin
        // cke low, masks high until the clock has been stable  R1 R2 R3
        next_mask = 1'b1;
        next_cke  = 1'b0;
        if (wait_cnt == '0)
        begin
          next_cke = 1'b1;
          next_st  = C_PRE;
        end
      end
      C_PRE:
      begin
        next_cmd      = CMD_PRE;             // R4
        next_addr     = ADDR_ALL_BANKS;
        next_wait_cnt = cyc(RP_CYC);         // R17
        next_st       = C_TRP;
      end
      C_TRP:
        if (wait_cnt == '0)
          next_st = C_REF;
      C_REF:
      begin
        // refreshes first, then mode set  R6 R7
        if (wait_cnt == '0)
        begin
          if (ref_cnt == CNT_W'(INIT_REFRESH_CNT))
            next_st = C_MRS;
          else
          begin
            next_cmd      = CMD_REF;
            next_ref_cnt  = ref_cnt + 1'b1;
            next_wait_cnt = cyc(RC_CYC);
          end
        end
      end
      C_MRS:
      begin
        next_cmd       = CMD_MRS;            // R5
        next_addr      = MODE_DEFAULT;
        next_ref_cnt   = '0;
        next_init_done = 1'b1;
        next_st        = C_IDLE;
      end
      C_IDLE:
        if (self_req && wait_cnt == '0)
          next_st = USE_BURST ? C_BREF_IN : C_ENTER;
      C_BREF_IN, C_BREF_OUT:
      begin
        // back-to-back burst refresh around self-refresh  R16
        if (wait_cnt == '0)
        begin
          if (ref_cnt == CNT_W'(BURST_REFRESH))
          begin
            next_ref_cnt = '0;
            next_st      = (st == C_BREF_IN) ? C_ENTER : C_IDLE;
          end
          else
          begin
            next_cmd      = CMD_REF;
            next_ref_cnt  = ref_cnt + 1'b1;
            next_wait_cnt = cyc(RC_CYC);
          end
        end
      end
      C_ENTER:
      begin
        // refresh encoding with cke low, write strobe high  R8 R20
        next_cmd         = CMD_REF;
        next_cke         = 1'b0;
        next_self_active = 1'b1;
        next_wait_cnt    = cyc(RAS_CYC);     // R11 R18
        next_st          = C_DWELL;
      end
      C_DWELL:
      begin
        next_cke = 1'b0;                     // R10
        if (wait_cnt == '0)
          next_st = C_SELF;
      end
      C_SELF:
      begin
        // clock may stop; device only looks at cke  R9
        next_cke     = 1'b0;
        next_clk_run = 1'b0;
        if (!self_req)
        begin
          next_clk_run  = 1'b1;
          next_wait_cnt = cyc(2);
          next_st       = C_CLKUP;
        end
      end
      C_CLKUP:
      begin
        // clock restarted, let it settle before cke  R12
        next_cke = 1'b0;
        if (wait_cnt == '0)
        begin
          next_cke      = 1'b1;
          next_cmd      = CMD_DESEL;         // R14
          next_wait_cnt = cyc(RC_CYC) > cyc(SRX_CYC) ? cyc(RC_CYC) : cyc(SRX_CYC); // R13 R15 R19
          next_st       = C_EXIT;
        end
      end
      C_EXIT:
      begin
        next_cmd = CMD_DESEL;                // R14
        if (wait_cnt == '0)
        begin
          next_self_active = 1'b0;
          next_st          = USE_BURST ? C_BREF_OUT : C_IDLE;
        end
      end
      default:
        next_st = C_STABLE;
    endcase
  end

  // ****************************************************************
  // registers; link pins come straight from flops
  // ****************************************************************
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st                  <= C_STABLE;
      wait_cnt            <= CNT_W'(STABLE_CYCLES - 1);  // R2
      ref_cnt             <= '0;
      link.cke            <= 1'b0;                       // R1
      {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_NOP;
      link.addr           <= 11'h000;
      link.ba             <= 1'b0;
      link.low_byte_mask  <= 1'b1;
      link.high_byte_mask <= 1'b1;
      link.clk_run        <= 1'b1;
      init_done           <= 1'b0;
      self_active         <= 1'b0;
    end
    else
    begin
      st                  <= next_st;
      wait_cnt            <= next_wait_cnt;
      ref_cnt             <= next_ref_cnt;
      link.cke            <= next_cke;
      {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= next_cmd;
      link.addr           <= next_addr;
      link.ba             <= 1'b0;
      link.low_byte_mask  <= next_mask;
      link.high_byte_mask <= next_mask;
      link.clk_run        <= next_clk_run;
      init_done           <= next_init_done;
      self_active         <= next_self_active;
    end
  end
endmodule : sis_ctrl

// file: dv/sis_link_sva.sv
// checker for the link between sis_ctrl and sis_dev
// assumes one clk and the async active-high reset
`timescale 1ns/10ps
module sis_link_sva
  import sis_pkg::*;
#(
  parameter int STABLE_CYCLES = STABLE_CYC // power-up wait
)
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        cke,
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic [10:0] addr,
  input wire logic        ba,
  input wire logic        low_byte_mask,
  input wire logic        high_byte_mask,
  input wire logic        clk_run
);
  // ****
  // helper state
  // ****
  logic [3:0]  cmd;      // strobes as one code
  logic        up;       // cke seen high since reset
  logic [15:0] age;      // cycles since reset, saturating
  logic        next_up;
  logic [15:0] next_age;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  // next helper values; age saturates so long runs never wrap
  always_comb
  begin
    next_up  = up | cke;
    next_age = (age == 16'hFFFF) ? age : age + 16'h0001;
  end
  // helper registers
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      up  <= 1'b0;
      age <= 16'h0000;
    end
    else
    begin
      up  <= next_up;
      age <= next_age;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ****
  // properties
  // ****
  property p_quiet;
    !up && !cke |-> low_byte_mask && high_byte_mask && cmd == CMD_NOP;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("link not quiet at power-up");
  property p_stable;
    $rose(cke) && !up |-> age >= STABLE_CYCLES - 1;
  endproperty
  a_stable: assert property (p_stable)
    else $error("cke raised too early");
  property p_pre;
    $rose(cke) && !up |=> cmd == CMD_PRE && addr[10];
  endproperty
  a_pre: assert property (p_pre)
    else $error("no precharge-all after cke");
  property p_init;
    $rose(cke) && !up |-> ##3 cmd == CMD_REF ##3 cmd == CMD_REF ##4 cmd == CMD_MRS;
  endproperty
  a_init: assert property (p_init)
    else $error("init refresh or mode set missing");
  property p_entry;
    $fell(cke) && up |-> cmd == CMD_REF;
  endproperty
  a_entry: assert property (p_entry)
    else $error("bad self-refresh entry command");
  property p_dwell;
    $fell(cke) && up |-> !cke [*3];
  endproperty
  a_dwell: assert property (p_dwell)
    else $error("self-refresh left too soon");
  property p_burst_in;
    $fell(cke) && up |-> $past(cmd, 4) == CMD_REF;
  endproperty
  a_burst_in: assert property (p_burst_in)
    else $error("no refresh burst before entry");
  property p_restart;
    $rose(cke) && up |-> $past(clk_run) && $past(clk_run, 2);
  endproperty
  a_restart: assert property (p_restart)
    else $error("clock not restarted before cke");
  property p_exit;
    $rose(cke) && up |-> (cke && cs_n) [*3];
  endproperty
  a_exit: assert property (p_exit)
    else $error("command too soon after exit");
  property p_burst_out;
    $rose(cke) && up |-> ##[3:6] cmd == CMD_REF && cke;
  endproperty
  a_burst_out: assert property (p_burst_out)
    else $error("no refresh burst after exit");
  // main scenarios reached
  c_init: cover property ($rose(cke) && !up);
  c_entry: cover property ($fell(cke) && up);
  c_exit: cover property ($rose(cke) && up);
endmodule : sis_link_sva

// file: dv/sis_tb.sv
// bench: sis_ctrl facing sis_dev, plus a driver on a second dev giving one illegal and one legal init order
// assumes the src files are compiled first
`timescale 1ns/10ps
module sdram_init_self_refresh_seq_tb
  import sis_pkg::*;
;
  localparam int STABLE = 20; // shortened power-up wait
  localparam int BURST  = 4;  // shortened refresh burst
  logic        clk;
  logic        reset;
  logic        self_req;
  logic        init_done;
  logic        self_active;
  logic [1:0]  dev_state;
  logic        in_self;
  logic [10:0] mode_value;
  logic [1:0]  bad_state;   // fault end status
  int          fail_count;
  int          n_tests;
  int          n_ref = 0;   // refreshes seen on the link
  int          base;
  int          n;
  sis_link_if sis_link_if_inst();
  sis_link_if sis_link_if_bad_inst();
  sis_ctrl #(.STABLE_CYCLES(STABLE), .BURST_REFRESH(BURST), .USE_BURST(1'b1)) sis_ctrl_inst (
    .clk(clk), .reset(reset), .link(sis_link_if_inst), .self_req(self_req),
    .init_done(init_done), .self_active(self_active));
  sis_dev sis_dev_inst (.clk(clk), .reset(reset), .link(sis_link_if_inst),
    .dev_state(dev_state), .in_self(in_self), .mode_value(mode_value));
  sis_dev sis_dev_bad_inst (.clk(clk), .reset(reset), .link(sis_link_if_bad_inst),
    .dev_state(bad_state), .in_self(), .mode_value());
  sis_link_sva #(.STABLE_CYCLES(STABLE)) sis_link_sva_inst (
    .clk(clk), .reset(reset), .cke(sis_link_if_inst.cke), .cs_n(sis_link_if_inst.cs_n),
    .ras_n(sis_link_if_inst.ras_n), .cas_n(sis_link_if_inst.cas_n), .we_n(sis_link_if_inst.we_n),
    .addr(sis_link_if_inst.addr), .ba(sis_link_if_inst.ba),
    .low_byte_mask(sis_link_if_inst.low_byte_mask), .high_byte_mask(sis_link_if_inst.high_byte_mask),
    .clk_run(sis_link_if_inst.clk_run));
  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // count refreshes with cke high; entry command has cke low and is left out
  always @(posedge clk)
    if (sis_link_if_inst.cke === 1'b1 && {sis_link_if_inst.cs_n, sis_link_if_inst.ras_n,
        sis_link_if_inst.cas_n, sis_link_if_inst.we_n} === CMD_REF)
      n_ref <= n_ref + 1;
  // ****
  // tasks
  // ****
  // fault driver: one command on the second link
  task automatic bad_cmd(input logic c, input logic [3:0] k, input logic [10:0] a);
    sis_link_if_bad_inst.cke <= c;
    {sis_link_if_bad_inst.cs_n, sis_link_if_bad_inst.ras_n, sis_link_if_bad_inst.cas_n,
      sis_link_if_bad_inst.we_n} <= k;
    sis_link_if_bad_inst.addr <= a;
    sis_link_if_bad_inst.ba <= 1'b0;
    sis_link_if_bad_inst.low_byte_mask <= 1'b1;
    sis_link_if_bad_inst.high_byte_mask <= 1'b1;
    sis_link_if_bad_inst.clk_run <= 1'b1;
  endtask : bad_cmd
  function automatic logic pick(input int k);
    case (k)
      0: return init_done;
      1: return self_active;
      2: return in_self;
      default: return logic'(n_ref - base == BURST);
    endcase
  endfunction : pick
  // bounded wait; a timeout ends the run
  task automatic wait_on(input int k, input logic v, output int w);
    w = 0;
    while (pick(k) !== v && w < 3000)
    begin
      @(posedge clk);
      #1;
      w++;
    end
    if (w >= 3000)
    begin
      fail_count++;
      $display("wrong value at %0t: wait %0d timed out", $time, k);
      stop_test();
    end
  endtask : wait_on
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("compares %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  // ****
  // main sequence: two passes, the second after a mid-run reset
  // ****
  initial
  begin
    fail_count = 0;
    n_tests = 0;
    reset = 1'b1;
    self_req = 1'b0;
    bad_cmd(1'b0, CMD_NOP, 11'h000);
    for (int p = 0; p < 2; p++)
    begin
      @(posedge clk);
      reset <= 1'b1;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      self_req <= 1'b1; // early request must wait for init
      @(posedge clk);
      #1;
      chk({4'h0, sis_link_if_inst.cke, sis_link_if_inst.low_byte_mask, sis_link_if_inst.high_byte_mask,
        sis_link_if_inst.cs_n, sis_link_if_inst.ras_n, sis_link_if_inst.cas_n, sis_link_if_inst.we_n},
        {4'h0, 3'h3, CMD_NOP});
      base = n_ref;
      wait_on(0, 1'b1, n);
      chk(11'(n >= STABLE), 11'h001);
      // device end registers the mode set one edge after init_done
      @(posedge clk);
      #1;
      chk(mode_value, MODE_DEFAULT);
      chk({9'h000, dev_state}, {9'h000, DEV_READY});
      chk(11'(n_ref - base), 11'h002);
      // burst count starts here, before the fault scenarios take edges
      base = n_ref;
      if (p == 0)
      begin
        // cke up, then mode set before any precharge: must be refused
        @(posedge clk);
        bad_cmd(1'b1, CMD_NOP, 11'h000);
        @(posedge clk);
        bad_cmd(1'b1, CMD_MRS, 11'h000);
        @(posedge clk);
        bad_cmd(1'b1, CMD_NOP, 11'h000);
        @(posedge clk);
        #1;
        chk({9'h000, bad_state}, {9'h000, DEV_ERROR});
      end
      else
      begin
        // mode set ahead of the refreshes must be accepted
        @(posedge clk);
        bad_cmd(1'b1, CMD_PRE, ADDR_ALL_BANKS);
        @(posedge clk);
        bad_cmd(1'b1, CMD_MRS, MODE_DEFAULT);
        @(posedge clk);
        bad_cmd(1'b1, CMD_REF, 11'h000);
        @(posedge clk);
        bad_cmd(1'b1, CMD_REF, 11'h000);
        @(posedge clk);
        bad_cmd(1'b1, CMD_NOP, 11'h000);
        @(posedge clk);
        #1;
        chk({9'h000, bad_state}, {9'h000, DEV_READY});
      end
      wait_on(1, 1'b1, n);
      chk(11'(n_ref - base), 11'(BURST));
      wait_on(2, 1'b1, n);
      chk({9'h000, dev_state}, {9'h000, DEV_SELF});
      repeat (10) @(posedge clk);
      #1;
      chk({10'h000, in_self}, 11'h001);
      @(posedge clk);
      self_req <= 1'b0;
      base = n_ref;
      wait_on(2, 1'b0, n);
      chk({9'h000, dev_state}, {9'h000, DEV_READY});
      wait_on(3, 1'b1, n);
      repeat (10) @(posedge clk);
      #1;
      chk({10'h000, self_active}, 11'h000);
      chk(11'(n_ref - base), 11'(BURST));
    end
    stop_test();
  end
endmodule : sdram_init_self_refresh_seq_tb
